// *** pkg/asr_defs.svh ***
// Register offsets, field positions, reset values and sample counts
// for the asynchronous serial receiver. Included by bare name.
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH
`define ASR_OFF_DIV_LO 8'h00
`define ASR_OFF_DIV_HI 8'h04
`define ASR_OFF_RXSTAT 8'h08
`define ASR_OFF_RXDATA 8'h0C
`define ASR_OFF_CFG 8'h10
`define ASR_OFF_EV_STAT 8'h14
`define ASR_OFF_EV_CLR 8'h18
`define ASR_OFF_EV_EN 8'h1C
`define ASR_OFF_INTCTL 8'h20
`define ASR_RS_SERIAL_PORT_ENABLE 7
`define ASR_RS_NINE 6
`define ASR_RS_CONTINUOUS_RECEIVE_ENABLE 4
`define ASR_RS_ADDRESS_DETECT_ENABLE 3
`define ASR_RS_WMASK 8'hD8
`define ASR_CF_SYNC 4
`define ASR_CF_WIDE 3
`define ASR_CF_HS 2
`define ASR_CF_PRIO 0
`define ASR_CF_WMASK 8'h1D
`define ASR_EV_RXC 0
`define ASR_EV_FRAMING_ERROR_FLAG 1
`define ASR_EV_OVERRUN_ERROR_FLAG 2
`define ASR_IC_GIE 7
`define ASR_IC_PERIPHERAL_INTERRUPT_ENABLE 6
`define ASR_IC_WMASK 8'hC0
`define ASR_RST_BYTE 8'h00
`define ASR_RST_CFG 8'h01
`define ASR_OS_MID 4'h7
`define ASR_OS_LAST 4'hF
`define ASR_PRE_SLOW 2'h3
`define ASR_LAST_BIT8 4'h7
`define ASR_LAST_BIT9 4'h8
`endif

// *** pkg/asr_pkg.sv ***
// Types shared by the serial receiver modules.
// Assumes nothing beyond a SystemVerilog compiler.
package asr_pkg;
   typedef enum logic [3:0] {
      ASR_IDLE = 4'h1,
      ASR_START = 4'h2,
      ASR_DATA = 4'h4,
      ASR_STOP = 4'h8
   } asr_state_t;
   typedef struct packed {
      logic hs;
      logic wide;
      logic [15:0] div;
   } asr_baud_t;
   typedef struct packed {
      logic [8:0] data;
      logic framing_error_flag;
   } asr_char_t;
endpackage

// *** rtl/asr_baud_gen.sv ***
// Baud divider producing the x16 oversampling strobe.
// Assumes divisor and mode bits are held steady while running.
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_baud_gen (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Sync reset, active high
   input wire logic run_i, // Port enabled
   input wire asr_pkg::asr_baud_t cfg_i, // Divisor and scaling
   output logic os_tick_o // One-cycle x16 sample strobe
);
   logic [1:0] pre_reg;
   logic [15:0] cnt_reg;
   logic pre_done;
   logic [15:0] n_eff;

   // Slow mode divides by 64 per bit: prescale by four
   assign pre_done = (cfg_i.hs || cfg_i.wide) ? 1'b1 :
                     (pre_reg == `ASR_PRE_SLOW); // RQ3
   // Narrow mode uses the low divisor byte only
   assign n_eff = cfg_i.wide ? cfg_i.div :
                  {8'h00, cfg_i.div[7:0]}; // RQ3

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i || pre_done) begin
         pre_reg <= 2'h0;
      end else begin
         pre_reg <= pre_reg + 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_reg <= 16'h0000;
      end else if (pre_done) begin
         if (cnt_reg == 16'h0000) begin
            cnt_reg <= n_eff; // RQ3
         end else begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         os_tick_o <= 1'b0;
      end else begin
         os_tick_o <= run_i && pre_done && (cnt_reg == 16'h0000); // RQ1
      end
   end
endmodule // asr_baud_gen

// *** rtl/asr_rx_shift.sv ***
// Oversampled data recovery and bit-rate receive shifter.
// Assumes a one-cycle x16 strobe and a line synchronous to clk_i.
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_rx_shift (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Sync reset, active high
   input wire logic en_i, // Reception allowed
   input wire logic os_tick_i, // x16 sample strobe
   input wire logic rxd_i, // Serial line, idle high
   input wire logic nine_i, // Nine data bits per character
   output logic done_o, // One-cycle character complete
   output asr_pkg::asr_char_t char_o // Data and stop-bit error
);
   asr_pkg::asr_state_t state_reg;
   logic [3:0] os_reg;
   logic [3:0] bit_reg;
   logic [8:0] sh_reg;
   logic [3:0] last_bit;
   logic at_mid;
   logic at_end;

   assign last_bit = nine_i ? `ASR_LAST_BIT9 : `ASR_LAST_BIT8; // RQ5
   assign at_mid = os_tick_i && (os_reg == `ASR_OS_MID);
   assign at_end = os_tick_i && (os_reg == `ASR_OS_LAST);

   // Dropping the enable aborts a half-received character
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         state_reg <= asr_pkg::ASR_IDLE;
         os_reg <= 4'h0;
         bit_reg <= 4'h0;
      end else begin
         if (os_tick_i) begin
            os_reg <= os_reg + 4'h1;
         end
         case (state_reg)
            asr_pkg::ASR_IDLE: begin
               os_reg <= 4'h0;
               if (os_tick_i && !rxd_i) begin
                  state_reg <= asr_pkg::ASR_START; // RQ17
               end
            end
            asr_pkg::ASR_START: begin
               if (at_mid) begin
                  os_reg <= 4'h0;
                  bit_reg <= 4'h0;
                  // Glitch shorter than half a bit is not a start
                  state_reg <= rxd_i ? asr_pkg::ASR_IDLE :
                               asr_pkg::ASR_DATA; // RQ1
               end
            end
            asr_pkg::ASR_DATA: begin
               if (at_end) begin
                  bit_reg <= bit_reg + 4'h1; // RQ2
                  if (bit_reg == last_bit) begin
                     state_reg <= asr_pkg::ASR_STOP; // RQ5
                  end
               end
            end
            asr_pkg::ASR_STOP: begin
               if (at_end) begin
                  state_reg <= asr_pkg::ASR_IDLE;
               end
            end
            default: begin
               state_reg <= asr_pkg::ASR_IDLE;
            end
         endcase
      end
   end

   // One bit per bit period, least significant first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_reg <= 9'h000;
      end else if (state_reg == asr_pkg::ASR_DATA && at_end) begin
         sh_reg <= {rxd_i, sh_reg[8:1]}; // RQ2 RQ17
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
         char_o <= '0;
      end else begin
         done_o <= en_i && state_reg == asr_pkg::ASR_STOP && at_end;
         if (state_reg == asr_pkg::ASR_STOP && at_end) begin
            char_o.data <= nine_i ? sh_reg : {1'b0, sh_reg[8:1]}; // RQ5
            char_o.framing_error_flag <= !rxd_i; // RQ16
         end
      end
   end
endmodule // asr_rx_shift

// *** rtl/asr_top.sv ***
// Asynchronous serial receiver with a classic Wishbone register slave.
// Assumes a synchronous receive line and a 32-bit classic bus master.
// Operation
// RQ1: Recover data sampling at sixteen times baud
// RQ2: Shift one recovered bit per bit period
// RQ3: Bit rate from divisor, speed and width
// RQ4: Asynchronous when port enabled, sync clear
// RQ5: Nine data bits if enabled, else eight
// RQ6: Accept characters only while receive enabled
// RQ7: Completion sets flag; interrupt only if enabled
// RQ8: Ninth bit and errors readable in status
// RQ9: Low eight bits readable in data register
// RQ10: Clearing receive enable clears latched errors
// RQ11: Interrupt needs global and peripheral enables
// RQ12: Address filtering when detect and nine set
// RQ13: Without detect, load every character, flag each
// RQ14: Priority bit routes interrupt high or low
// RQ15: Detect mode keeps only ninth-bit-one characters
// RQ16: Low stop is framing error; full is overrun
// RQ17: Sender frames start low, LSB first, stop high
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_top (
   input wire logic clk_i, // System clock, 125 MHz
   input wire logic rst_i, // Sync reset, active high
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic wb_we_i, // Write enable
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Bus acknowledge
   input wire logic serial_receive_pin_i, // Receive line
   output logic irq_high_o, // High-priority interrupt
   output logic irq_low_o // Low-priority interrupt
);
   logic [7:0] div_lo_reg;
   logic [7:0] div_hi_reg;
   logic [7:0] rs_ctl_reg;
   logic [7:0] cfg_reg;
   logic [7:0] intctl_reg;
   logic [7:0] rdata_reg;
   logic received_ninth_bit_reg;
   logic framing_error_flag_reg;
   logic overrun_error_flag_reg;
   logic full_reg;
   logic [2:0] ev_stat_reg;
   logic [2:0] ev_stat_next;
   logic [2:0] ev_en_reg;
   logic [2:0] ev_set;
   logic [2:0] ev_clr;
   logic [7:0] rd_byte;
   logic acc;
   logic wr;
   logic pop;
   logic serial_port_enable;
   logic nine;
   logic continuous_receive_enable;
   logic address_detect_enable;
   logic async_on;
   logic rx_en;
   logic os_tick;
   logic rx_done;
   logic keep;
   logic load;
   logic overrun;
   logic pend;
   asr_pkg::asr_baud_t baud_cfg;
   asr_pkg::asr_char_t rx_char;

   assign serial_port_enable = rs_ctl_reg[`ASR_RS_SERIAL_PORT_ENABLE];
   assign nine = rs_ctl_reg[`ASR_RS_NINE];
   assign continuous_receive_enable = rs_ctl_reg[`ASR_RS_CONTINUOUS_RECEIVE_ENABLE];
   assign address_detect_enable = rs_ctl_reg[`ASR_RS_ADDRESS_DETECT_ENABLE];
   assign async_on = serial_port_enable && !cfg_reg[`ASR_CF_SYNC]; // RQ4
   // Overrun stalls reception until software clears the enable
   assign rx_en = async_on && continuous_receive_enable && !overrun_error_flag_reg; // RQ6 RQ16
   assign baud_cfg = {cfg_reg[`ASR_CF_HS], cfg_reg[`ASR_CF_WIDE],
                      div_hi_reg, div_lo_reg}; // RQ3

   asr_baud_gen u_baud (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(async_on),
      .cfg_i(baud_cfg),
      .os_tick_o(os_tick)
   );

   asr_rx_shift u_shift (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(rx_en),
      .os_tick_i(os_tick),
      .rxd_i(serial_receive_pin_i),
      .nine_i(nine),
      .done_o(rx_done),
      .char_o(rx_char)
   );

   // Address filter only applies together with nine-bit reception
   assign keep = !(address_detect_enable && nine) || rx_char.data[8]; // RQ12 RQ13 RQ15
   assign load = rx_done && rx_en && keep && !full_reg; // RQ13
   assign overrun = rx_done && rx_en && keep && full_reg; // RQ16

   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = acc && wb_we_i && wb_sel_i[0];
   assign pop = acc && !wb_we_i && (wb_adr_i == `ASR_OFF_RXDATA);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= acc;
      end
   end

   always_comb begin
      case (wb_adr_i)
         `ASR_OFF_DIV_LO: rd_byte = div_lo_reg;
         `ASR_OFF_DIV_HI: rd_byte = div_hi_reg;
         `ASR_OFF_RXSTAT: rd_byte = rs_ctl_reg |
            {5'h00, framing_error_flag_reg, overrun_error_flag_reg, received_ninth_bit_reg}; // RQ8
         `ASR_OFF_RXDATA: rd_byte = rdata_reg; // RQ9
         `ASR_OFF_CFG: rd_byte = cfg_reg;
         `ASR_OFF_EV_STAT: rd_byte = {5'h00, ev_stat_reg};
         `ASR_OFF_EV_EN: rd_byte = {5'h00, ev_en_reg};
         `ASR_OFF_INTCTL: rd_byte = intctl_reg;
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (acc && !wb_we_i) begin
         wb_dat_o <= {24'h000000, rd_byte};
      end
   end

   // Software-written control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_lo_reg <= `ASR_RST_BYTE;
         div_hi_reg <= `ASR_RST_BYTE;
         rs_ctl_reg <= `ASR_RST_BYTE;
         cfg_reg <= `ASR_RST_CFG;
         intctl_reg <= `ASR_RST_BYTE;
         ev_en_reg <= 3'h0;
      end else if (wr) begin
         case (wb_adr_i)
            `ASR_OFF_DIV_LO: div_lo_reg <= wb_dat_i[7:0];
            `ASR_OFF_DIV_HI: div_hi_reg <= wb_dat_i[7:0];
            `ASR_OFF_RXSTAT: rs_ctl_reg <= wb_dat_i[7:0] & `ASR_RS_WMASK;
            `ASR_OFF_CFG: cfg_reg <= wb_dat_i[7:0] & `ASR_CF_WMASK;
            `ASR_OFF_INTCTL: intctl_reg <= wb_dat_i[7:0] & `ASR_IC_WMASK;
            `ASR_OFF_EV_EN: ev_en_reg <= wb_dat_i[2:0];
            default: ev_en_reg <= ev_en_reg;
         endcase
      end
   end

   // Single-entry receive buffer; a new load beats a same-cycle read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         full_reg <= 1'b0;
      end else if (load) begin
         full_reg <= 1'b1;
      end else if (pop) begin
         full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
         received_ninth_bit_reg <= 1'b0;
      end else if (load) begin
         rdata_reg <= rx_char.data[7:0]; // RQ9
         received_ninth_bit_reg <= rx_char.data[8]; // RQ8
      end
   end

   // Overrun holds until the receive enable is cleared; framing error is rewritten by each load
   always_ff @(posedge clk_i) begin
      if (rst_i || !continuous_receive_enable) begin
         framing_error_flag_reg <= 1'b0; // RQ10
         overrun_error_flag_reg <= 1'b0; // RQ10
      end else begin
         if (load) begin
            framing_error_flag_reg <= rx_char.framing_error_flag; // RQ16
         end
         if (overrun) begin
            overrun_error_flag_reg <= 1'b1; // RQ16
         end
      end
   end

   // Sticky events: a set in the clearing cycle survives
   assign ev_set = {overrun, load && rx_char.framing_error_flag, load}; // RQ7
   assign ev_clr = (wr && wb_adr_i == `ASR_OFF_EV_CLR) ?
                   wb_dat_i[2:0] : {2'h0, pop};
   assign ev_stat_next = (ev_stat_reg & ~ev_clr) | ev_set;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_stat_reg <= 3'h0;
      end else begin
         ev_stat_reg <= ev_stat_next;
      end
   end

   assign pend = |(ev_stat_reg & ev_en_reg) &&
                 intctl_reg[`ASR_IC_GIE] &&
                 intctl_reg[`ASR_IC_PERIPHERAL_INTERRUPT_ENABLE]; // RQ7 RQ11

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_high_o <= 1'b0;
         irq_low_o <= 1'b0;
      end else begin
         irq_high_o <= pend && cfg_reg[`ASR_CF_PRIO]; // RQ14
         irq_low_o <= pend && !cfg_reg[`ASR_CF_PRIO]; // RQ14
      end
   end

   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_single_pulse:
   assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_ack_next_cycle:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");

   a_flag_on_load: // RQ7
   assert property (load |=> ev_stat_reg[`ASR_EV_RXC])
      else $error("receive complete flag not set");

   a_data_loaded: // RQ9
   assert property (load |=> rdata_reg == $past(rx_char.data[7:0]))
      else $error("received byte not in data register");

   a_ninth_bit: // RQ8
   assert property (load |=> received_ninth_bit_reg == $past(rx_char.data[8]))
      else $error("ninth bit not in status");

   a_addr_filter: // RQ15
   assert property (rx_done && address_detect_enable && nine && !rx_char.data[8]
                    |=> $stable(rdata_reg) && !$rose(full_reg))
      else $error("non-address character loaded");

   a_err_cleared: // RQ10
   assert property (!continuous_receive_enable |=> !framing_error_flag_reg && !overrun_error_flag_reg)
      else $error("error survived receive disable");

   a_overrun_stall: // RQ16
   assert property (overrun |=> overrun_error_flag_reg && !rx_en ##1 !rx_done)
      else $error("overrun not latched or not stalling");

   a_irq_gate: // RQ11
   assert property ((irq_high_o || irq_low_o) |->
                    $past(intctl_reg[`ASR_IC_GIE]) &&
                    $past(intctl_reg[`ASR_IC_PERIPHERAL_INTERRUPT_ENABLE]))
      else $error("interrupt without global enables");

   a_irq_route: // RQ14
   assert property (pend |=> irq_high_o == $past(cfg_reg[`ASR_CF_PRIO])
                    && irq_low_o != $past(cfg_reg[`ASR_CF_PRIO]))
      else $error("interrupt on wrong priority line");

   c_char_loaded: cover property (load ##[1:60] pop);
   c_overrun: cover property ($rose(overrun_error_flag_reg));
   c_addr_drop: cover property (rx_done && address_detect_enable && nine && !keep);
   c_irq_high: cover property ($rose(irq_high_o));
endmodule // asr_top

// *** tb/asr_serial_tx.sv ***
// Behavioural remote transmitter driving the receive line.
// Assumes go_i is a one-cycle request raised while busy_o is low.
`timescale 1ns/1ps
module asr_serial_tx (
   input wire logic clk_i, // System clock
   input wire logic go_i, // Send one frame
   input wire logic [8:0] data_i, // Character
   input wire logic nine_i, // Send ninth bit
   input wire logic stop_i, // Stop level, low breaks framing
   input wire logic [7:0] bit_clks_i, // Clocks per bit
   output logic line_o, // Serial line, idle high
   output logic busy_o // Frame in progress
);
   logic [10:0] frame;
   int nbits;
   initial begin
      line_o = 1'b1;
      busy_o = 1'b0;
   end
   always begin
      do @(posedge clk_i); while (go_i !== 1'b1);
      frame = {stop_i, data_i, 1'b0};
      if (!nine_i) begin
         frame = {1'b1, stop_i, data_i[7:0], 1'b0};
      end
      nbits = nine_i ? 11 : 10;
      busy_o <= 1'b1;
      for (int i = 0; i < nbits; i++) begin
         line_o <= frame[i];
         repeat (bit_clks_i) @(posedge clk_i);
      end
      // Line returns to idle high between frames
      line_o <= 1'b1;
      busy_o <= 1'b0;
   end
endmodule // asr_serial_tx

// *** tb/asr_top_bench.sv ***
// Self-checking bench for the serial receiver over classic Wishbone.
// Assumes the partner transmitter model and the register map header.
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_top_bench;
   localparam logic [7:0] ST = `ASR_OFF_RXSTAT;
   localparam logic [7:0] EV = `ASR_OFF_EV_STAT;
   localparam logic [7:0] DT = `ASR_OFF_RXDATA;
   localparam logic [7:0] CF = `ASR_OFF_CFG;
   localparam logic [7:0] IC = `ASR_OFF_INTCTL;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, bclk = 8'h20;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, line, irq_h, irq_l, busy;
   logic go = 1'b0, nine = 1'b0, stp = 1'b1;
   logic [8:0] txd = 9'h000;
   int bad_count = 0;
   int num_checks = 0;
   always #4 clk = ~clk;
   asr_top dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .serial_receive_pin_i(line), .irq_high_o(irq_h), .irq_low_o(irq_l));
   asr_serial_tx tx_u (.clk_i(clk), .go_i(go), .data_i(txd),
      .nine_i(nine), .stop_i(stp), .bit_clks_i(bclk), .line_o(line),
      .busy_o(busy));
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) bad_count++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_irq(input logic [1:0] e);
      num_checks++;
      if ({irq_h, irq_l} !== e) begin
         bad_count++;
         $display("BAD irq expected %b seen %b", e, {irq_h, irq_l});
      end
   endtask
   task automatic rd(input logic [7:0] a, input string nm,
         input logic [31:0] e);
      wb(1'b0, a, 8'h00);
      chk(nm, e, q);
   endtask
   // Ends once the partner drops busy, after the stop bit
   task automatic send(input logic [8:0] d, input logic n9,
         input logic s);
      int n;
      n = 0;
      txd <= d;
      nine <= n9;
      stp <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (busy === 1'b1 && n < 2000);
      if (n >= 2000) bad_count++;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Eleven frames of at most 640 clocks plus bus traffic
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`ASR_OFF_DIV_LO, "div_lo", 32'h0);
      rd(CF, "cfg", 32'h1);
      rd(ST, "rxstat", 32'h0);
      wb(1'b1, 8'h24, 8'hFF);
      rd(8'h24, "unmapped", 32'h0);
      $display("test reset done");
      // Wide divisor 1 gives two clocks per strobe, 32 per bit
      wb(1'b1, `ASR_OFF_DIV_LO, 8'h01);
      wb(1'b1, CF, 8'h09);
      wb(1'b1, IC, 8'hC0);
      wb(1'b1, `ASR_OFF_EV_EN, 8'h01);
      wb(1'b1, ST, 8'h90);
      send(9'h0A5, 1'b0, 1'b1);
      rd(EV, "ev", 32'h1);
      chk_irq(2'b10);
      rd(DT, "data", 32'hA5);
      rd(EV, "ev", 32'h0);
      chk_irq(2'b00);
      $display("test basic done");
      wb(1'b1, CF, 8'h08);
      wb(1'b1, IC, 8'h40);
      send(9'h05A, 1'b0, 1'b1);
      chk_irq(2'b00);
      wb(1'b1, IC, 8'hC0);
      chk_irq(2'b01);
      rd(DT, "data", 32'h5A);
      $display("test priority done");
      wb(1'b1, ST, 8'hD0);
      send(9'h13C, 1'b1, 1'b1);
      rd(ST, "rxstat", 32'hD1);
      rd(DT, "data", 32'h3C);
      wb(1'b1, ST, 8'hD8);
      send(9'h055, 1'b1, 1'b1);
      rd(EV, "ev", 32'h0);
      send(9'h1AA, 1'b1, 1'b1);
      rd(EV, "ev", 32'h1);
      rd(DT, "data", 32'hAA);
      $display("test ninth bit done");
      wb(1'b1, ST, 8'h90);
      send(9'h0F0, 1'b0, 1'b0);
      rd(ST, "rxstat", 32'h94);
      rd(EV, "ev", 32'h3);
      send(9'h00F, 1'b0, 1'b1);
      rd(ST, "rxstat", 32'h96);
      rd(EV, "ev", 32'h7);
      wb(1'b1, ST, 8'h80);
      rd(ST, "rxstat", 32'h80);
      wb(1'b1, `ASR_OFF_EV_CLR, 8'h07);
      rd(`ASR_OFF_EV_CLR, "ev_clr", 32'h0);
      rd(DT, "data", 32'hF0);
      send(9'h033, 1'b0, 1'b1);
      rd(EV, "ev", 32'h0);
      $display("test errors done");
      // Slow mode, divisor 0: four clocks per strobe, 64 per bit
      wb(1'b1, CF, 8'h01);
      wb(1'b1, `ASR_OFF_DIV_LO, 8'h00);
      bclk <= 8'h40;
      wb(1'b1, ST, 8'h90);
      send(9'h0C3, 1'b0, 1'b1);
      chk_irq(2'b10);
      rd(DT, "data", 32'hC3);
      $display("test slow baud done");
      // Sync select keeps the receiver off
      wb(1'b1, CF, 8'h15);
      send(9'h066, 1'b0, 1'b1);
      rd(EV, "ev", 32'h0);
      // High speed, narrow: high byte ignored, two clocks per strobe
      wb(1'b1, `ASR_OFF_DIV_HI, 8'h01);
      wb(1'b1, `ASR_OFF_DIV_LO, 8'h01);
      wb(1'b1, CF, 8'h05);
      bclk <= 8'h20;
      send(9'h096, 1'b0, 1'b1);
      chk_irq(2'b10);
      rd(`ASR_OFF_DIV_HI, "div_hi", 32'h1);
      rd(DT, "data", 32'h96);
      $display("test high speed done");
      // Second reset in mid-run restores the reset values
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_irq(2'b00);
      rd(DT, "data", 32'h0);
      rd(CF, "cfg", 32'h1);
      rd(`ASR_OFF_DIV_HI, "div_hi", 32'h0);
      $display("test mid reset done");
      wrap_up();
   end
endmodule // asr_top_bench
